// *** hdl/cantw_core.sv ***
`timescale 1ns/1ps
module cantw_core
    import cantw_pkg::*;
#(
    parameter int unsigned PULSE_MAX = PULSE_MAX_CYC,
    parameter int unsigned GAP_MAX   = GAP_MAX_CYC,
    parameter int unsigned WIN_MAX   = WINDOW_CYC
) (
    // Clock and reset
    input  wire logic              clk_i,
    input  wire logic              rst_b_i,
    // Control
    input  wire logic              sleep_req_i,
    input  wire logic              transceive_mode_req_i,
    input  wire logic              wake_en_i,
    input  wire logic [SLEW_W-1:0] slew_i,
    input  wire logic              stop_mode_i,
    input  wire logic              second_supply_rail_i,
    // Controller side
    input  wire logic              txd_i,
    output logic                   rxd_o,
    // Bus side
    input  wire logic              bus_dom_i,
    input  wire logic              wu_dom_i,
    output logic                   drv_dom_o,
    output logic                   drv_en_b_o,
    output logic                   rcv_en_o,
    // Status
    output logic                   transceive_mode_o,
    output logic                   bus_wake_flag_o,
    output logic                   wake_o,
    output logic                   int_pulse_o
);
    localparam logic [CNT_W-1:0] C_MIN = CNT_W'(PULSE_MIN_CYC);
    localparam logic [CNT_W-1:0] C_MAX = CNT_W'(PULSE_MAX);
    localparam logic [CNT_W-1:0] C_GAP = CNT_W'(GAP_MAX);
    localparam logic [CNT_W-1:0] C_WIN = CNT_W'(WIN_MAX);
    localparam logic [CNT_W-1:0] C_ONE = CNT_W'(1);
    localparam logic [7:0] S_STEP = 8'(SLEW_STEP);

    // Pin synchronisers
    logic [1:0] s_txd, s_bus, s_wu;
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            s_txd <= 2'b11;
            s_bus <= 2'b00;
            s_wu  <= 2'b00;
        end else begin
            s_txd <= {s_txd[0], txd_i};
            s_bus <= {s_bus[0], bus_dom_i};
            s_wu  <= {s_wu[0], wu_dom_i};
        end
    end
    logic txd_s, bus_s, wu_s;
    assign txd_s = s_txd[1];
    assign bus_s = s_bus[1];
    assign wu_s  = s_wu[1];

    // Mode control
    cantw_mode_t mode, next_mode;
    logic        wake_flag, next_wake_flag;
    logic        arming;
    // Shared decode of the one mode in which the bus is served
    function automatic logic is_transceive_mode(input cantw_mode_t m);
        return m == CANTW_TRANSCEIVE_MODE;
    endfunction
    always_comb begin
        next_mode = mode;
        case (mode)
            CANTW_TRANSCEIVE_MODE: begin
                // Rail state deliberately ignored here
                if (sleep_req_i) begin
                    next_mode = CANTW_SLEEP;
                end
            end
            CANTW_SLEEP: begin
                if (transceive_mode_req_i) begin
                    next_mode = CANTW_RESUME;
                end
            end
            CANTW_RESUME: begin
                // One cycle held recessive before following the pin
                next_mode = sleep_req_i ? CANTW_SLEEP : CANTW_TRANSCEIVE_MODE;
            end
            default: begin
                next_mode = CANTW_TRANSCEIVE_MODE;
            end
        endcase
    end
    assign arming = (mode == CANTW_SLEEP) && wake_en_i;

    // Slew shaping: a step delay per setting on driven edges
    logic [7:0] slew_cnt, next_slew_cnt;
    logic       drv, next_drv;
    logic       drv_tgt;
    assign drv_tgt = is_transceive_mode(mode) && !txd_s;
    always_comb begin
        next_slew_cnt = slew_cnt;
        next_drv      = drv;
        if (!is_transceive_mode(mode)) begin
            next_drv      = 1'b0;
            next_slew_cnt = 8'h00;
        end else if (drv_tgt != drv) begin
            if (slew_cnt >= 8'(slew_i) * S_STEP) begin
                next_drv      = drv_tgt;
                next_slew_cnt = 8'h00;
            end else begin
                next_slew_cnt = slew_cnt + 8'h01;
            end
        end else begin
            next_slew_cnt = 8'h00;
        end
    end

    // Wake-up pattern detection
    logic [CNT_W-1:0] wid, next_wid, gap, next_gap, win, next_win;
    logic [1:0]       pcnt, next_pcnt;
    logic             wu_d, next_wu_d, wake_ev;
    always_comb begin
        next_wid  = wid;
        next_gap  = gap;
        next_win  = win;
        next_pcnt = pcnt;
        next_wu_d = wu_s;
        wake_ev   = 1'b0;
        if (!arming || wake_flag) begin
            next_wid  = '0;
            next_gap  = '0;
            next_win  = '0;
            next_pcnt = 2'h0;
        end else begin
            // Counters run on the core clock
            if (wu_s && wid != C_MAX) begin
                next_wid = wid + C_ONE;
            end
            if (!wu_s) begin
                next_wid = '0;
            end
            if (pcnt != 2'h0) begin
                if (gap != C_GAP) begin
                    next_gap = gap + C_ONE;
                end
                if (win != C_WIN) begin
                    next_win = win + C_ONE;
                end
            end
            if (wu_d && !wu_s) begin
                // Only width matters, not frame content
                if (wid > C_MIN && wid < C_MAX) begin
                    // Window opens at the rising edge of the first pulse,
                    // so its width counts against the pattern time
                    if (win >= C_WIN) begin
                        next_pcnt = 2'h1;
                        next_win  = wid;
                    end else if (pcnt == PULSES_WAKE - 2'h1) begin
                        next_pcnt = PULSES_WAKE;
                        wake_ev   = 1'b1;
                    end else begin
                        next_pcnt = pcnt + 2'h1;
                        if (pcnt == 2'h0) begin
                            next_win = wid;
                        end
                    end
                    next_gap = '0;
                end else begin
                    next_pcnt = 2'h0;
                    next_win  = '0;
                    next_gap  = '0;
                end
            end else if (pcnt != 2'h0 && gap >= C_GAP) begin
                next_pcnt = 2'h0;
                next_win  = '0;
                next_gap  = '0;
            end
        end
    end
    always_comb begin
        next_wake_flag = wake_flag;
        if (mode == CANTW_RESUME) begin
            next_wake_flag = 1'b0;
        end
        if (wake_ev) begin
            next_wake_flag = 1'b1;
        end
    end

    // Receive pin parks high while the receiver is off
    logic int_p, next_int_p, next_rxd;
    always_comb begin
        next_int_p = wake_ev && stop_mode_i;
        next_rxd   = is_transceive_mode(mode) ? !bus_s : 1'b1;
    end
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            mode      <= CANTW_TRANSCEIVE_MODE;
            slew_cnt  <= 8'h00;
            drv       <= 1'b0;
            wid       <= '0;
            gap       <= '0;
            win       <= '0;
            pcnt      <= 2'h0;
            wu_d      <= 1'b0;
            wake_flag <= 1'b0;
            int_p     <= 1'b0;
            rxd_o     <= 1'b1;
        end else begin
            mode      <= next_mode;
            slew_cnt  <= next_slew_cnt;
            drv       <= next_drv;
            wid       <= next_wid;
            gap       <= next_gap;
            win       <= next_win;
            pcnt      <= next_pcnt;
            wu_d      <= next_wu_d;
            wake_flag <= next_wake_flag;
            int_p     <= next_int_p;
            rxd_o     <= next_rxd;
        end
    end

    assign drv_dom_o         = drv;
    assign drv_en_b_o        = !is_transceive_mode(mode);
    assign rcv_en_o          = is_transceive_mode(mode);
    assign transceive_mode_o = is_transceive_mode(mode);
    assign bus_wake_flag_o   = wake_flag;
    assign wake_o            = wake_flag;
    assign int_pulse_o       = int_p;

    logic unused_rail;
    assign unused_rail = second_supply_rail_i;

    sleep_drv_off_a: assert property (
        @(posedge clk_i) disable iff (!rst_b_i)
        mode == CANTW_SLEEP |-> drv_en_b_o && !drv_dom_o && !rcv_en_o)
        else $error("Driver active in sleep");
    rx_parked_a: assert property (
        @(posedge clk_i) disable iff (!rst_b_i)
        !is_transceive_mode(mode) |=> rxd_o)
        else $error("Receive pin not parked high");
    sleep_any_rail_a: assert property (
        @(posedge clk_i) disable iff (!rst_b_i)
        mode == CANTW_TRANSCEIVE_MODE && sleep_req_i |=> mode == CANTW_SLEEP)
        else $error("Sleep request not taken");
    resume_recess_a: assert property (
        @(posedge clk_i) disable iff (!rst_b_i)
        mode == CANTW_RESUME |-> !drv_dom_o ##1 !drv_dom_o)
        else $error("Resume not recessive");
    slew_hold_a: assert property (
        @(posedge clk_i) disable iff (!rst_b_i)
        is_transceive_mode(mode) && !sleep_req_i && slew_cnt < 8'(slew_i) * S_STEP
        |=> $stable(drv_dom_o))
        else $error("Driver edge before slew delay");
    tx_follow_a: assert property (
        @(posedge clk_i) disable iff (!rst_b_i)
        is_transceive_mode(mode) && !sleep_req_i && slew_i == 2'h0
        |=> drv_dom_o == !$past(txd_s))
        else $error("Driver does not follow transmit pin");
    wake_needs_en_a: assert property (
        @(posedge clk_i) disable iff (!rst_b_i)
        $rose(wake_flag) |-> $past(arming))
        else $error("Wake without enable");
    counters_idle_a: assert property (
        @(posedge clk_i) disable iff (!rst_b_i)
        !arming |=> pcnt == 2'h0 && gap == '0 && win == '0)
        else $error("Wake counters not cleared");
    wake_three_a: assert property (
        @(posedge clk_i) disable iff (!rst_b_i)
        $rose(wake_flag) |-> $past(pcnt) == PULSES_WAKE - 2'h1)
        else $error("Wake before three pulses");
    good_pulse_cnt_a: assert property (
        @(posedge clk_i) disable iff (!rst_b_i)
        arming && !wake_flag && wu_d && !wu_s && wid > C_MIN && wid < C_MAX
        && win < C_WIN |=> pcnt == $past(pcnt) + 2'h1)
        else $error("Accepted pulse not counted");
    bad_pulse_clr_a: assert property (
        @(posedge clk_i) disable iff (!rst_b_i)
        arming && !wake_flag && wu_d && !wu_s && wid <= C_MIN |=> pcnt == 2'h0)
        else $error("Short pulse kept count");
    long_pulse_clr_a: assert property (
        @(posedge clk_i) disable iff (!rst_b_i)
        arming && !wake_flag && wu_d && !wu_s && wid >= C_MAX |=> pcnt == 2'h0)
        else $error("Long pulse kept count");
    gap_clear_a: assert property (
        @(posedge clk_i) disable iff (!rst_b_i)
        arming && !wake_flag && pcnt != 2'h0 && gap >= C_GAP
        && !(wu_d && !wu_s) |=> pcnt == 2'h0)
        else $error("Gap timeout kept count");
    gap_tick_a: assert property (
        @(posedge clk_i) disable iff (!rst_b_i)
        arming && !wake_flag && pcnt != 2'h0 && gap < C_GAP
        && !(wu_d && !wu_s) |=> gap == $past(gap) + C_ONE)
        else $error("Gap timer not running");
    win_restart_a: assert property (
        @(posedge clk_i) disable iff (!rst_b_i)
        arming && !wake_flag && wu_d && !wu_s && wid > C_MIN && wid < C_MAX
        && win >= C_WIN |=> pcnt == 2'h1 && !wake_flag)
        else $error("Wake outside pattern window");
    flag_hold_a: assert property (
        @(posedge clk_i) disable iff (!rst_b_i)
        wake_flag && mode != CANTW_RESUME |=> wake_flag)
        else $error("Wake flag dropped early");
    flag_clear_a: assert property (
        @(posedge clk_i) disable iff (!rst_b_i)
        mode == CANTW_RESUME |=> !wake_flag)
        else $error("Wake flag kept in transceive");
    int_stop_a: assert property (
        @(posedge clk_i) disable iff (!rst_b_i)
        wake_ev && stop_mode_i |=> int_pulse_o ##1 !int_pulse_o || wake_ev)
        else $error("Stop wake pulse missing");
    int_cause_a: assert property (
        @(posedge clk_i) disable iff (!rst_b_i)
        int_pulse_o |-> $past(wake_ev && stop_mode_i) && bus_wake_flag_o)
        else $error("Interrupt pulse without stop wake");
    rx_follow_a: assert property (
        @(posedge clk_i) disable iff (!rst_b_i)
        mode == CANTW_TRANSCEIVE_MODE && $past(mode) == CANTW_TRANSCEIVE_MODE |=>
        rxd_o == !$past(bus_s))
        else $error("Receive output wrong");
endmodule

// *** hdl/cantw_pkg.sv ***
package cantw_pkg;
    localparam int unsigned CLK_MHZ      = 250;
    localparam int unsigned PULSE_MIN_NS = 500;
    localparam int unsigned PULSE_MAX_US = 500;
    localparam int unsigned GAP_MAX_US   = 500;
    localparam int unsigned WINDOW_US    = 1000;
    localparam int unsigned PULSE_MIN_CYC = PULSE_MIN_NS * CLK_MHZ / 1000;
    localparam int unsigned PULSE_MAX_CYC = PULSE_MAX_US * CLK_MHZ;
    localparam int unsigned GAP_MAX_CYC   = GAP_MAX_US * CLK_MHZ;
    localparam int unsigned WINDOW_CYC    = WINDOW_US * CLK_MHZ;
    localparam int unsigned CNT_W         = 20;
    localparam logic [1:0]  PULSES_WAKE   = 2'h3;
    localparam int unsigned SLEW_W        = 2;
    localparam int unsigned SLEW_STEP     = 4;
    typedef enum logic [1:0] {
        CANTW_TRANSCEIVE_MODE     = 2'b00,
        CANTW_SLEEP    = 2'b01,
        CANTW_RESUME   = 2'b10
    } cantw_mode_t;
endpackage

// *** testbench/cantw_bus_model.sv ***
`timescale 1ns/1ps
module cantw_bus_model (
    // Clock
    input  wire logic clk_i,
    // Device bus side
    input  wire logic drv_dom_i,
    input  wire logic drv_en_b_i,
    output logic      bus_dom_o,
    output logic      wu_dom_o
);
    // Remote traffic; a terminated bus idles recessive, so it reads low
    logic remote_dom;
    initial remote_dom = 1'b0;
    // Wired dominant: enabled local driver or any remote node
    assign bus_dom_o = remote_dom | (drv_dom_i & ~drv_en_b_i);
    assign wu_dom_o  = remote_dom;
    // One dominant pulse then a recessive gap, counted in cycles
    task automatic pulse(input int w, input int g);
        @(negedge clk_i);
        remote_dom = 1'b1;
        repeat (w) @(negedge clk_i);
        remote_dom = 1'b0;
        repeat (g) @(negedge clk_i);
    endtask
endmodule

// *** testbench/tb_can_transceiver_mode_wakeup.sv ***
`timescale 1ns/1ps
module tb_can_transceiver_mode_wakeup;
    import cantw_pkg::*;
    logic       clk_i = 1'b0;
    logic       rst_b_i = 1'b0;
    logic       sleep_req_i = 1'b0;
    logic       transceive_mode_req_i = 1'b0;
    logic       wake_en_i = 1'b0;
    logic [1:0] slew_i = 2'h0;
    logic       stop_mode_i = 1'b0;
    logic       rail = 1'b0;
    logic       txd_i = 1'b1;
    logic       rxd_o, bus_dom, wu_dom, drv_dom, drv_en_b, rcv_en;
    logic       tm, flag, wake, int_pulse;
    int         num_errors = 0;
    int         n_checks = 0;
    int         n_int = 0;
    int         seed = 32'he343;
    logic [6:0] notes[$];
    event       smp;
    localparam logic [6:0] IDLE = 7'h58;
    localparam logic [6:0] DOM  = 7'h54;
    localparam logic [6:0] SLP  = 7'h28;
    always #2 clk_i = ~clk_i;
    cantw_core #(.PULSE_MAX(400), .GAP_MAX(400), .WIN_MAX(800)) i_dut (
        .clk_i(clk_i), .rst_b_i(rst_b_i), .sleep_req_i(sleep_req_i),
        .transceive_mode_req_i(transceive_mode_req_i), .wake_en_i(wake_en_i), .slew_i(slew_i),
        .stop_mode_i(stop_mode_i), .second_supply_rail_i(rail),
        .txd_i(txd_i), .rxd_o(rxd_o), .bus_dom_i(bus_dom),
        .wu_dom_i(wu_dom), .drv_dom_o(drv_dom), .drv_en_b_o(drv_en_b),
        .rcv_en_o(rcv_en), .transceive_mode_o(tm),
        .bus_wake_flag_o(flag), .wake_o(wake), .int_pulse_o(int_pulse));
    cantw_bus_model i_bus (.clk_i(clk_i), .drv_dom_i(drv_dom),
        .drv_en_b_i(drv_en_b), .bus_dom_o(bus_dom), .wu_dom_o(wu_dom));
    task automatic chk(input string nm, input logic [6:0] seen,
                       input logic [6:0] exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic note(input logic [6:0] e);
        notes.push_back(e);
        ->smp;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk_i);
    endtask
    // Three pulses inside width, gap and window limits
    task automatic burst();
        repeat (3) i_bus.pulse(126 + ($unsigned($random(seed)) % 8), 150);
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // Oldest note is compared when the driver flags a result
    always begin
        @(smp);
        #0.5;
        chk("status", {tm, drv_en_b, rcv_en, rxd_o, drv_dom, flag, wake},
            notes.pop_front());
    end
    always @(posedge clk_i) if (int_pulse === 1'b1) n_int++;
    initial begin
        #80000;
        num_errors++;
        report_and_stop();
    end
    initial begin
        cyc(16);
        rst_b_i = 1'b1;
        cyc(3);
        note(IDLE);
        for (int s = 0; s < 4; s++) begin
            slew_i = s[1:0];
            txd_i = 1'b0;
            cyc(3);
            // Slow settings must still hold the edge back here
            if (s >= 2) note(IDLE);
            cyc(20);
            note(DOM);
            txd_i = 1'b1;
            cyc(24);
            note(IDLE);
        end
        $display("test transceive_mode done");
        rail = 1'($random(seed));
        sleep_req_i = 1'b1;
        txd_i = 1'b0;
        cyc(4);
        sleep_req_i = 1'b0;
        note(SLP);
        burst();
        note(SLP);
        wake_en_i = 1'b1;
        i_bus.pulse(130, 150);
        i_bus.pulse(130, 150);
        i_bus.pulse(125, 150);
        i_bus.pulse(130, 150);
        i_bus.pulse(130, 150);
        note(SLP);
        // A long first pulse would otherwise complete the pattern
        i_bus.pulse(450, 10);
        i_bus.pulse(130, 10);
        i_bus.pulse(130, 450);
        i_bus.pulse(130, 150);
        note(SLP);
        i_bus.pulse(130, 300);
        i_bus.pulse(130, 300);
        i_bus.pulse(130, 150);
        note(SLP);
        // Gaps pass, but first rise to third fall exceeds the window
        i_bus.pulse(390, 200);
        i_bus.pulse(190, 200);
        i_bus.pulse(190, 150);
        note(SLP);
        wake_en_i = 1'b0;
        cyc(4);
        wake_en_i = 1'b1;
        stop_mode_i = 1'b1;
        burst();
        note(SLP | 7'h03);
        chk("int", n_int[6:0], 7'h01);
        burst();
        note(SLP | 7'h03);
        chk("int", n_int[6:0], 7'h01);
        transceive_mode_req_i = 1'b1;
        cyc(1);
        transceive_mode_req_i = 1'b0;
        txd_i = 1'b1;
        cyc(4);
        note(IDLE);
        $display("test sleep done");
        report_and_stop();
    end
endmodule
